/* File: rtl/adc_gpio_pkg.sv */
// Types shared by the channel configuration block.
// Assumes the constants of adc_gpio_regs.svh for field meaning.
package adc_gpio_pkg;

  // Conversion sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACQ = 3'h2,
    ST_CONV = 3'h4
  } conv_state_t;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] pin_func;
    logic [7:0] pin_dir;
    logic [7:0] out_level;
    logic [7:0] drv_type;
    logic [7:0] in_level;
    logic [7:0] pin_out;
    logic [7:0] pin_oe_n;
    logic seq_en;
    logic avg_en;
    logic [2:0] man_chan;
    logic busy;
    logic [17:0] rst_cnt;
    conv_state_t state;
    logic [4:0] timer;
    logic [2:0] chan;
    logic [3:0] avg_cnt;
    logic [15:0] acc;
    logic [15:0] result;
    logic [2:0] res_chan;
    logic res_valid;
    logic sw;
    logic conv;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } top_state_t;

endpackage : adc_gpio_pkg

/* File: rtl/adc_gpio_regs.svh */
// Register offsets, field positions, reset values and timing counts.
// Assumes a 40 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef ADC_GPIO_REGS_SVH
`define ADC_GPIO_REGS_SVH

// Register byte offsets (low address byte)
`define OFF_CTRL 8'h00
`define OFF_PIN_FUNC 8'h04
`define OFF_PIN_DIR 8'h08
`define OFF_OUT_LEVEL 8'h0C
`define OFF_DRV_TYPE 8'h10
`define OFF_IN_LEVEL 8'h14
`define OFF_RESULT 8'h18

// Control register fields
`define CTRL_RST_BIT 0
`define CTRL_START_BIT 1
`define CTRL_SEQ_BIT 2
`define CTRL_AVG_BIT 3
`define CTRL_CHAN_LSB 4
`define CTRL_CHAN_MSB 6
`define CTRL_READY_BIT 8

// Result register fields
`define RES_DATA_MSB 15
`define RES_CHAN_LSB 16
`define RES_CHAN_MSB 18
`define RES_VALID_BIT 24

// Reset values: every channel analog, outputs low, open-drain
`define PIN_FUNC_RST 8'h00
`define PIN_DIR_RST 8'h00
`define OUT_LEVEL_RST 8'h00
`define DRV_TYPE_RST 8'h00
`define CHAN_RST 3'h0

// Timing, in ns, and derived cycle counts
`define CLK_PERIOD_NS 25
`define T_ACQ_NS 400
`define T_CONV_NS 600
`define T_RST_NS 5000000
`define ACQ_CYC ((`T_ACQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC (`T_CONV_NS / `CLK_PERIOD_NS)
`define RST_CYC (`T_RST_NS / `CLK_PERIOD_NS)

// Samples summed per averaged result
`define AVG_SAMPLES 16

`endif

/* File: rtl/adc_gpio_sync.sv */
// Three-stage synchroniser with agreement filter for pin-side inputs.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
module adc_gpio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Asynchronous input and filtered result
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // Shift chain; a bit counts once stages two and three agree
  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.out = (q.out & (q.s2 ^ q.s3)) | (q.s2 & ~(q.s2 ^ q.s3));
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.out;

endmodule : adc_gpio_sync

/* File: rtl/adc_gpio_top.sv */
// Channel configuration, GPIO and conversion control with an AHB-Lite slave.
// Assumes one 40 MHz clock, an analog core that returns a 12-bit code.
// What this block does
// - After power-up or any reset every one of eight channels is analog.
// - Per-channel function select picks analog or digital use.
// - Per-channel direction picks input or output for digital channels.
// - Host reads the sampled level of digital input channels.
// - Digital outputs drive the level written in the output level bits.
// - Per-channel driver bit selects open-drain or push-pull output.
// - Soft-reset bit resets configuration, sequencer and result, then clears itself within 5 ms.
// - Each 12-bit result is an unsigned straight-binary code.
// - Averaging gives a 16-bit result of higher resolution.
// - Channel selection can step automatically in sequence.
// - Conversions are timed internally, never by the host clock.
// - Sampling switch closed in acquisition, open through conversion.
// - Function 0 analog; 1 with direction 0 input, 1 output; driver bit.
// - Level readback covers digital inputs and digital outputs alike.
`timescale 1ns/1ps
`include "adc_gpio_regs.svh"
module adc_gpio_top #(
  parameter int RST_CYCLES = `RST_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Multiplexed channel pins
  input wire logic [7:0] multiplexed_channel_pin_in,
  output logic [7:0] multiplexed_channel_pin_out,
  output logic [7:0] multiplexed_channel_pin_oe_n,
  // Analog core
  input wire logic [11:0] adc_code,
  output logic [2:0] mux_sel,
  output logic sampling_switch,
  output logic convert_active
);

  adc_gpio_pkg::top_state_t q;
  adc_gpio_pkg::top_state_t d;
  logic [7:0] pin_sync;
  logic [11:0] code_sync;

  // Pin levels come from outside the clock domain
  adc_gpio_sync #(
    .WIDTH(8)
  ) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(multiplexed_channel_pin_in),
    .sync_out(pin_sync)
  );

  // Analog core code settles asynchronously to clk
  adc_gpio_sync #(
    .WIDTH(12)
  ) u_code_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(adc_code),
    .sync_out(code_sync)
  );

  // Next-state logic: bus, reset timer, sequencer, pins
  always_comb begin
    logic [31:0] rd;
    logic [15:0] sample;
    logic [15:0] sum;
    logic start;
    rd = 32'h0000_0000;
    sample = {4'h0, code_sync};
    sum = q.acc + sample;
    start = 1'b0;
    d = q;
    d.hready = 1'b1;
    d.hresp = 1'b0;

    // Read mux, sampled in the address phase
    case (haddr[7:0])
      `OFF_CTRL: begin
        rd[`CTRL_RST_BIT] = q.busy;
        rd[`CTRL_SEQ_BIT] = q.seq_en;
        rd[`CTRL_AVG_BIT] = q.avg_en;
        rd[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB] = q.man_chan;
        rd[`CTRL_READY_BIT] = ~q.busy;
      end
      `OFF_PIN_FUNC: rd[7:0] = q.pin_func;
      `OFF_PIN_DIR: rd[7:0] = q.pin_dir;
      `OFF_OUT_LEVEL: rd[7:0] = q.out_level;
      `OFF_DRV_TYPE: rd[7:0] = q.drv_type;
      `OFF_IN_LEVEL: rd[7:0] = q.in_level;
      `OFF_RESULT: begin
        rd[`RES_DATA_MSB:0] = q.result;
        rd[`RES_CHAN_MSB:`RES_CHAN_LSB] = q.res_chan;
        rd[`RES_VALID_BIT] = q.res_valid;
      end
      default: rd = 32'h0000_0000;
    endcase
    d.wr_pend = hsel & htrans[1] & hready & hwrite;
    d.wr_addr = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite) begin
      d.hrdata = rd;
    end

    // Conversion sequencer on the internal clock
    case (q.state)
      adc_gpio_pkg::ST_IDLE: begin
        d.sw = 1'b0;
        d.conv = 1'b0;
      end
      adc_gpio_pkg::ST_ACQ: begin
        d.timer = q.timer + 5'h01;
        if (q.timer == 5'(`ACQ_CYC - 1)) begin
          d.state = adc_gpio_pkg::ST_CONV;
          d.timer = 5'h00;
          d.sw = 1'b0;
          d.conv = 1'b1;
        end
      end
      adc_gpio_pkg::ST_CONV: begin
        d.timer = q.timer + 5'h01;
        if (q.timer == 5'(`CONV_CYC - 1)) begin
          d.timer = 5'h00;
          d.conv = 1'b0;
          if (q.avg_en && q.avg_cnt != 4'(`AVG_SAMPLES - 1)) begin
            // Further averaging samples launched internally
            d.avg_cnt = q.avg_cnt + 4'h1;
            d.acc = sum;
            d.state = adc_gpio_pkg::ST_ACQ;
            d.sw = 1'b1;
          end else begin
            d.result = q.avg_en ? sum : sample;
            d.res_chan = q.chan;
            d.res_valid = 1'b1;
            d.state = adc_gpio_pkg::ST_IDLE;
            if (q.seq_en) begin
              d.chan = q.chan + 3'h1;
            end
          end
        end
      end
      default: begin
        d.state = adc_gpio_pkg::ST_IDLE;
        d.sw = 1'b0;
        d.conv = 1'b0;
      end
    endcase

    // Register writes in the data phase; ignored while reset runs
    if (q.wr_pend && !q.busy) begin
      case (q.wr_addr)
        `OFF_CTRL: begin
          if (hwdata[`CTRL_RST_BIT]) begin
            d.busy = 1'b1;
            d.rst_cnt = 18'h0_0000;
          end else begin
            d.seq_en = hwdata[`CTRL_SEQ_BIT];
            d.avg_en = hwdata[`CTRL_AVG_BIT];
            d.man_chan = hwdata[`CTRL_CHAN_MSB:`CTRL_CHAN_LSB];
            start = hwdata[`CTRL_START_BIT] && q.state == adc_gpio_pkg::ST_IDLE;
          end
        end
        `OFF_PIN_FUNC: d.pin_func = hwdata[7:0];
        `OFF_PIN_DIR: d.pin_dir = hwdata[7:0];
        `OFF_OUT_LEVEL: d.out_level = hwdata[7:0];
        `OFF_DRV_TYPE: d.drv_type = hwdata[7:0];
        default: d.wr_pend = d.wr_pend;
      endcase
    end

    // Start of an acquisition, channel from sequence or manual field
    if (start) begin
      d.state = adc_gpio_pkg::ST_ACQ;
      d.sw = 1'b1;
      d.timer = 5'h00;
      d.avg_cnt = 4'h0;
      d.acc = 16'h0000;
      d.res_valid = 1'b0;
      if (!d.seq_en) begin
        d.chan = d.man_chan;
      end
    end

    // Soft or power-up reset: configuration, sequencer and result back to defaults, then release
    if (d.busy) begin
      d.pin_func = `PIN_FUNC_RST;
      d.pin_dir = `PIN_DIR_RST;
      d.out_level = `OUT_LEVEL_RST;
      d.drv_type = `DRV_TYPE_RST;
      d.seq_en = 1'b0;
      d.avg_en = 1'b0;
      d.man_chan = `CHAN_RST;
      d.chan = `CHAN_RST;
      d.state = adc_gpio_pkg::ST_IDLE;
      d.sw = 1'b0;
      d.conv = 1'b0;
      d.timer = 5'h00;
      d.res_valid = 1'b0;
      d.result = 16'h0000;
      d.res_chan = `CHAN_RST;
    end
    if (q.busy) begin
      d.rst_cnt = q.rst_cnt + 18'h0_0001;
      if (q.rst_cnt == 18'(RST_CYCLES - 1)) begin
        d.busy = 1'b0;
        d.rst_cnt = 18'h0_0000;
      end
    end

    // Pin drivers and level readback
    d.pin_out = q.out_level;
    d.pin_oe_n = ~(q.pin_func & q.pin_dir & (q.drv_type | ~q.out_level));
    d.in_level = pin_sync & q.pin_func;
  end

  // State register; reset starts the power-up timer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.state <= adc_gpio_pkg::ST_IDLE;
      q.pin_oe_n <= 8'hFF;
      q.busy <= 1'b1;
      q.hready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.hrdata;
  assign hreadyout = q.hready;
  assign hresp = q.hresp;
  assign multiplexed_channel_pin_out = q.pin_out;
  assign multiplexed_channel_pin_oe_n = q.pin_oe_n;
  assign mux_sel = q.chan;
  assign sampling_switch = q.sw;
  assign convert_active = q.conv;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_RESET_ANALOG: assert property ($rose(q.busy) |-> q.pin_func == `PIN_FUNC_RST)
    else $error("channels not analog after reset");
  AST_RST_RELEASE: assert property (
    (q.busy && q.rst_cnt == 18'(RST_CYCLES - 1)) |=> !q.busy ##1 !q.busy)
    else $error("reset bit did not clear on time");
  AST_RST_BOUND: assert property (q.busy |-> q.rst_cnt <= 18'(RST_CYCLES - 1))
    else $error("reset timer overran");
  AST_ANALOG_NO_DRIVE: assert property ((~q.pin_oe_n & ~$past(q.pin_func)) == 8'h00)
    else $error("analog channel driven");
  AST_INPUT_NO_DRIVE: assert property ((~q.pin_oe_n & $past(~q.pin_dir)) == 8'h00)
    else $error("input channel driven");
  AST_PUSH_PULL: assert property (
    ($past(q.pin_func & q.pin_dir & q.drv_type) & q.pin_oe_n) == 8'h00)
    else $error("push-pull output not driven");
  AST_OPEN_DRAIN: assert property (
    ($past(q.pin_func & q.pin_dir & ~q.drv_type & q.out_level) & ~q.pin_oe_n) == 8'h00)
    else $error("open-drain output drove high");
  AST_OUT_LEVEL: assert property (q.pin_out == $past(q.out_level))
    else $error("output level mismatch");
  AST_READBACK: assert property (q.in_level == $past(pin_sync & q.pin_func))
    else $error("level readback mismatch");
  AST_SWITCH_OPEN: assert property (q.conv |-> !q.sw)
    else $error("switch closed during conversion");
  AST_ACQ_HOLD: assert property ($rose(q.sw) && !d.busy |-> q.sw [*8])
    else $error("acquisition cut short");
  AST_STRAIGHT: assert property (
    ($rose(q.res_valid) && !q.avg_en) |-> q.result == {4'h0, $past(code_sync)})
    else $error("single result not straight binary");
  AST_SEQ_STEP: assert property (
    ($fell(q.conv) && q.state == adc_gpio_pkg::ST_IDLE && q.seq_en && !q.busy)
      |-> q.chan == $past(q.chan) + 3'h1)
    else $error("sequencer did not advance");

endmodule : adc_gpio_top

/* File: verification/adc_channel_gpio_config_bench.sv */
// Bench for the channel block: AHB-Lite tasks and directed tests.
// Assumes a short reset count; every bus phase waits on hreadyout.
`timescale 1ns/1ps
`include "adc_gpio_regs.svh"
module adc_channel_gpio_config_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sampling_switch, convert_active;
  logic [7:0] pin_level, pin_out, pin_oe_n;
  logic [11:0] adc_code;
  logic [2:0] mux_sel;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  adc_gpio_top #(.RST_CYCLES(20)) adc_gpio_top_inst (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .multiplexed_channel_pin_in(pin_level), .multiplexed_channel_pin_out(pin_out),
    .multiplexed_channel_pin_oe_n(pin_oe_n), .adc_code(adc_code), .mux_sel(mux_sel),
    .sampling_switch(sampling_switch), .convert_active(convert_active));
  pin_model pin_model_inst (
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en), .ext_val(ext_val),
    .pin_level(pin_level), .mux_sel(mux_sel), .adc_code(adc_code));
  // Clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  // Verdict
  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  // One AHB-Lite single transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0; // Select released between transfers
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : xfer
  // Read until a bit is set, bounded
  task automatic poll(input logic [7:0] a, input int b, output logic [31:0] r);
    r = 32'h0;
    for (int n = 0; n < 2000 && r[b] !== 1'b1; n++) xfer(1'b0, a, 32'h0, r);
  endtask : poll
  // Expected result word
  function automatic logic [31:0] res(input logic [2:0] ch, input logic avg);
    logic [11:0] c;
    c = {ch, 9'h0A5};
    return {7'h0, 1'b1, 5'h0, ch, avg ? {c, 4'h0} : {4'h0, c}};
  endfunction : res
  // Pin configs: func, dir, out, driver, source enable, source value
  logic [47:0] cfg [4] = '{48'hFF00_0000_FFA5, 48'hF0C0_C040_0F0F,
                           48'hF0F0_A030_8000, 48'h0F0F_FF0F_0000};
  initial begin
    logic [31:0] r;
    logic [7:0] f, d, o, t, ee, ev, on, lv;
    int n;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk({24'h0, pin_oe_n}, 32'hFF);
    xfer(1'b0, `OFF_CTRL, 32'h0, r);
    chk(r, 32'h1);
    poll(`OFF_CTRL, 8, r);
    chk(r, 32'h100);
    for (int a = 4; a <= 16; a += 4) begin
      xfer(1'b0, 8'(a), 32'h0, r);
      chk(r, 32'h0);
    end
    // Every channel code, driver kind, and outside faults
    for (int k = 0; k < 4; k++) begin
      {f, d, o, t, ee, ev} = cfg[k];
      ext_en <= ee;
      ext_val <= ev;
      xfer(1'b1, `OFF_PIN_FUNC, {24'h0, f}, r);
      xfer(1'b1, `OFF_PIN_DIR, {24'h0, d}, r);
      xfer(1'b1, `OFF_OUT_LEVEL, {24'h0, o}, r);
      xfer(1'b1, `OFF_DRV_TYPE, {24'h0, t}, r);
      repeat (10) @(posedge clk);
      on = f & d & (t | ~o);
      lv = (on & o) | (~on & (~ee | ev));
      chk({24'h0, pin_oe_n}, {24'h0, ~on});
      chk({24'h0, pin_out & on}, {24'h0, o & on});
      xfer(1'b0, `OFF_IN_LEVEL, 32'h0, r);
      chk(r, {24'h0, f & lv});
      xfer(1'b0, `OFF_PIN_FUNC, 32'h0, r);
      chk(r, {24'h0, f});
    end
    // Manual conversion on channel 3 with phase lengths
    xfer(1'b1, `OFF_CTRL, 32'h32, r);
    for (n = 0; n < 10 && sampling_switch !== 1'b1; n++) @(posedge clk);
    for (n = 0; sampling_switch === 1'b1; n++) @(posedge clk);
    chk(n, 16);
    for (n = 0; convert_active === 1'b1 && sampling_switch === 1'b0; n++) @(posedge clk);
    chk(n, 24);
    poll(`OFF_RESULT, 24, r);
    chk(r, res(3'h3, 1'b0));
    xfer(1'b1, `OFF_CTRL, 32'h5A, r);
    poll(`OFF_RESULT, 24, r);
    chk(r, res(3'h5, 1'b1));
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, `OFF_CTRL, 32'h06, r);
      poll(`OFF_RESULT, 24, r);
      chk(r, res(3'(5 + s), 1'b0));
    end
    chk({29'h0, mux_sel}, 32'h7);
    // Soft reset, writes refused while busy
    xfer(1'b1, `OFF_CTRL, 32'h1, r);
    xfer(1'b0, `OFF_CTRL, 32'h0, r);
    chk(r, 32'h1);
    xfer(1'b1, `OFF_PIN_FUNC, 32'hFF, r);
    xfer(1'b0, `OFF_PIN_FUNC, 32'h0, r);
    chk(r, 32'h0);
    chk({24'h0, pin_oe_n}, 32'hFF);
    chk({29'h0, mux_sel}, 32'h0);
    xfer(1'b0, `OFF_RESULT, 32'h0, r);
    chk(r, 32'h0);
    poll(`OFF_CTRL, 8, r);
    chk(r, 32'h100);
    // Unmapped place
    xfer(1'b1, 8'h40, 32'hFFFF_FFFF, r);
    xfer(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    stop_test();
  end
endmodule : adc_channel_gpio_config_bench

/* File: verification/pin_model.sv */
// Pin and analog core model on the far side of the channel block.
// Assumes pull-ups on every pin and a code that is steady per channel.
`timescale 1ns/1ps
module pin_model (
  // Pin side of the design
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // Outside sources on the pins
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_level,
  // Analog core
  input wire logic [2:0] mux_sel,
  output logic [11:0] adc_code
);
  // Wire level: own driver, else outside source, else pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
  // Code steady while a channel is held
  assign adc_code = {mux_sel, 9'h0A5};
endmodule : pin_model
